// >>> inc/mcct_pkg.sv
package mcct_pkg;

	// ***********************************************************
	// Register map (byte addresses)
	// ***********************************************************
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_COUNT  = 8'h04;
	localparam logic [7:0] ADDR_PRESC  = 8'h08;
	localparam logic [7:0] ADDR_PCOUNT = 8'h0c;
	localparam logic [7:0] ADDR_MCTRL  = 8'h10;
	localparam logic [7:0] ADDR_OCTRL  = 8'h14;
	localparam logic [7:0] ADDR_CCTRL  = 8'h18;
	localparam logic [7:0] ADDR_CAPT   = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam logic [7:0] ADDR_MASK   = 8'h24;
	localparam logic [7:0] ADDR_MOUT   = 8'h28;
	localparam logic [7:0] ADDR_MATCH0 = 8'h30;

	// ***********************************************************
	// Field positions
	// ***********************************************************
	localparam int CTRL_EN    = 0;
	localparam int CTRL_RST   = 1;
	localparam int CTRL_MODE  = 2;
	localparam int CCTRL_RISE = 0;
	localparam int CCTRL_FALL = 1;
	localparam int CCTRL_CLR  = 2;
	localparam int CCTRL_CLRF = 3;
	localparam int ST_CAP     = 4;
	localparam int N_MATCH    = 4;
	localparam int N_EVENT    = 5;

	// ***********************************************************
	// Encodings
	// ***********************************************************
	typedef enum logic [1:0]
	{
		MCCT_ACT_CONT  = 2'h0,
		MCCT_ACT_STOP  = 2'h1,
		MCCT_ACT_RESET = 2'h2
	} mcct_act_t;

	typedef enum logic [1:0]
	{
		MCCT_OUT_NONE   = 2'h0,
		MCCT_OUT_LOW    = 2'h1,
		MCCT_OUT_HIGH   = 2'h2,
		MCCT_OUT_TOGGLE = 2'h3
	} mcct_out_t;

	// Counter/external edge selection for counter mode
	typedef enum logic [1:0]
	{
		MCCT_CNT_RISE = 2'h0,
		MCCT_CNT_FALL = 2'h1,
		MCCT_CNT_BOTH = 2'h2
	} mcct_cnt_t;

	typedef struct packed
	{
		logic [1:0] in_sync;
		logic       in_prev;
		logic [1:0] cap_sync;
		logic       cap_prev;
	} mcct_sync_t;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage : mcct_pkg

// >>> hdl/mcct_timer.sv
// Contract
// - Counter width 32/16 fed by same-width prescaler
// - Timer mode or external-edge counter mode
// - Capture copies count on edge, optional interrupt
// - Four matches: continue, stop or reset, interrupt
// - Four outputs: low, high, toggle or nothing
// - Capture edge may clear counter and prescaler
// - Match outputs and capture input as triggers
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module mcct_timer #(
	parameter int WIDTH = 32
) (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        COUNT_IN,
	input  wire logic        CAP_IN,
	output logic [3:0]       MATCH_OUT,
	output logic [4:0]       TRIG_OUT,
	output logic             IRQ
);

	// ***********************************************************
	// State
	// ***********************************************************
	typedef struct packed
	{
		logic [2:0]             ctrl;
		logic [1:0]             cnt_edge;
		logic [WIDTH-1:0]       count;
		logic [WIDTH-1:0]       presc;
		logic [WIDTH-1:0]       pcount;
		logic [7:0]             mctrl;
		logic [7:0]             octrl;
		logic [3:0]             cctrl;
		logic [WIDTH-1:0]       capt;
		logic [4:0]             status;
		logic [4:0]             mask;
		logic [3:0]             mout;
		logic [4*WIDTH-1:0]     match;
		logic [4:0]             trig;
		mcct_pkg::mcct_sync_t   sync;
		logic                   wr_pend;
		logic [7:0]             wr_addr;
		logic [31:0]            rdata;
	} mcct_state_t;

	mcct_state_t st;
	mcct_state_t next_st;

	function automatic logic [WIDTH-1:0] fit(input logic [31:0] w);
		fit = w[WIDTH-1:0];
	endfunction : fit

	function automatic logic [31:0] widen(input logic [WIDTH-1:0] v);
		widen = 32'(v);
	endfunction : widen

	function automatic logic [WIDTH-1:0] match_of(
		input logic [4*WIDTH-1:0] m,
		input int                 i
	);
		match_of = m[i*WIDTH +: WIDTH];
	endfunction : match_of

	// ***********************************************************
	// Next state
	// ***********************************************************
	always_comb
	begin
		logic            a_phase;
		logic            cnt_en;
		logic            in_rise;
		logic            in_fall;
		logic            cap_rise;
		logic            cap_fall;
		logic            tick;
		logic            pre_done;
		logic            step;
		logic            do_cap;
		logic            do_clr;
		logic [3:0]      hit;
		logic            stop_hit;
		logic            reset_hit;
		logic [4:0]      ev;
		logic [7:0]      idx;
		logic [31:0]     rd;
		a_phase   = 1'b0;
		cnt_en    = 1'b0;
		in_rise   = 1'b0;
		in_fall   = 1'b0;
		cap_rise  = 1'b0;
		cap_fall  = 1'b0;
		tick      = 1'b0;
		pre_done  = 1'b0;
		step      = 1'b0;
		do_cap    = 1'b0;
		do_clr    = 1'b0;
		hit       = 4'h0;
		stop_hit  = 1'b0;
		reset_hit = 1'b0;
		ev        = 5'h00;
		idx       = 8'h00;
		rd        = mcct_pkg::RESET_WORD;
		next_st   = st;

		// Only the second sync stage feeds any logic
		next_st.sync.in_sync  = {st.sync.in_sync[0], COUNT_IN};
		next_st.sync.cap_sync = {st.sync.cap_sync[0], CAP_IN};
		next_st.sync.in_prev  = st.sync.in_sync[1];
		next_st.sync.cap_prev = st.sync.cap_sync[1];
		in_rise  = st.sync.in_sync[1] & ~st.sync.in_prev;
		in_fall  = ~st.sync.in_sync[1] & st.sync.in_prev;
		cap_rise = st.sync.cap_sync[1] & ~st.sync.cap_prev;
		cap_fall = ~st.sync.cap_sync[1] & st.sync.cap_prev;

		// Capture on selected edge; clear uses its own edge select
		do_cap = (st.cctrl[mcct_pkg::CCTRL_RISE] & cap_rise)
			| (st.cctrl[mcct_pkg::CCTRL_FALL] & cap_fall);
		do_clr = st.cctrl[mcct_pkg::CCTRL_CLR]
			& (st.cctrl[mcct_pkg::CCTRL_CLRF] ? cap_fall : cap_rise);

		cnt_en = st.ctrl[mcct_pkg::CTRL_EN] & ~st.ctrl[mcct_pkg::CTRL_RST];
		if (st.ctrl[mcct_pkg::CTRL_MODE])
		begin
			case (st.cnt_edge)
				mcct_pkg::MCCT_CNT_RISE: tick = in_rise;
				mcct_pkg::MCCT_CNT_FALL: tick = in_fall;
				mcct_pkg::MCCT_CNT_BOTH: tick = in_rise | in_fall;
				default:                 tick = 1'b0;
			endcase
		end
		else
		begin
			tick = 1'b1;
		end

		// Prescaler wraps at its terminal value, then counter steps
		if (cnt_en && tick)
		begin
			pre_done = (st.pcount == st.presc);
			next_st.pcount = pre_done ? '0 : st.pcount + 1'b1;
			step = pre_done;
		end

		// Matches judged on the value the counter steps to
		if (step)
		begin
			next_st.count = st.count + 1'b1;
			for (int i = 0; i < mcct_pkg::N_MATCH; i++)
			begin
				hit[i] = (next_st.count == match_of(st.match, i));
				if (hit[i])
				begin
					case (mcct_act_sel(st.mctrl, i))
						mcct_pkg::MCCT_ACT_STOP:  stop_hit  = 1'b1;
						mcct_pkg::MCCT_ACT_RESET: reset_hit = 1'b1;
						default:                  ;
					endcase
					case (mcct_out_sel(st.octrl, i))
						mcct_pkg::MCCT_OUT_LOW:    next_st.mout[i] = 1'b0;
						mcct_pkg::MCCT_OUT_HIGH:   next_st.mout[i] = 1'b1;
						mcct_pkg::MCCT_OUT_TOGGLE:
							next_st.mout[i] = ~st.mout[i];
						default:                   ;
					endcase
				end
			end
			if (reset_hit)
				next_st.count = '0;
			if (stop_hit)
				next_st.ctrl[mcct_pkg::CTRL_EN] = 1'b0;
		end

		if (do_clr || st.ctrl[mcct_pkg::CTRL_RST])
		begin
			next_st.count  = '0;
			next_st.pcount = '0;
		end
		if (do_cap)
			next_st.capt = st.count;

		// Trigger pulses for the converter
		next_st.trig = {do_cap, hit};

		ev = {do_cap, hit};

		// Bus: address phase latched, action in data phase
		a_phase = HSEL & HREADY & HTRANS[1];
		next_st.wr_pend = a_phase & HWRITE;
		next_st.wr_addr = HADDR[7:0];

		idx = HADDR[7:0];
		case (idx)
			mcct_pkg::ADDR_CTRL:   rd = 32'(st.ctrl);
			mcct_pkg::ADDR_COUNT:  rd = widen(st.count);
			mcct_pkg::ADDR_PRESC:  rd = widen(st.presc);
			mcct_pkg::ADDR_PCOUNT: rd = widen(st.pcount);
			mcct_pkg::ADDR_MCTRL:  rd = 32'(st.mctrl);
			mcct_pkg::ADDR_OCTRL:  rd = 32'(st.octrl);
			mcct_pkg::ADDR_CCTRL:  rd = 32'({st.cnt_edge, st.cctrl});
			mcct_pkg::ADDR_CAPT:   rd = widen(st.capt);
			mcct_pkg::ADDR_STATUS: rd = 32'(st.status);
			mcct_pkg::ADDR_MASK:   rd = 32'(st.mask);
			mcct_pkg::ADDR_MOUT:   rd = 32'(st.mout);
			default:
			begin
				rd = mcct_pkg::RESET_WORD;
				for (int i = 0; i < mcct_pkg::N_MATCH; i++)
					if (idx == mcct_pkg::ADDR_MATCH0 + 8'(4 * i))
						rd = widen(match_of(st.match, i));
			end
		endcase
		next_st.rdata = (a_phase & ~HWRITE) ? rd : st.rdata;

		// Sticky flags: hardware set beats software clear
		next_st.status = st.status & ~((st.wr_pend
			&& st.wr_addr == mcct_pkg::ADDR_STATUS)
			? HWDATA[4:0] : 5'h00);
		next_st.status = next_st.status | ev;

		if (st.wr_pend)
		begin
			case (st.wr_addr)
				mcct_pkg::ADDR_CTRL:   next_st.ctrl = HWDATA[2:0];
				mcct_pkg::ADDR_COUNT:  next_st.count = fit(HWDATA);
				mcct_pkg::ADDR_PRESC:  next_st.presc = fit(HWDATA);
				mcct_pkg::ADDR_PCOUNT: next_st.pcount = fit(HWDATA);
				mcct_pkg::ADDR_MCTRL:  next_st.mctrl = HWDATA[7:0];
				mcct_pkg::ADDR_OCTRL:  next_st.octrl = HWDATA[7:0];
				mcct_pkg::ADDR_CCTRL:
				begin
					next_st.cctrl    = HWDATA[3:0];
					next_st.cnt_edge = HWDATA[5:4];
				end
				mcct_pkg::ADDR_MASK:   next_st.mask = HWDATA[4:0];
				mcct_pkg::ADDR_MOUT:   next_st.mout = HWDATA[3:0];
				default:
				begin
					for (int i = 0; i < mcct_pkg::N_MATCH; i++)
						if (st.wr_addr == mcct_pkg::ADDR_MATCH0 + 8'(4 * i))
							next_st.match[i*WIDTH +: WIDTH] = fit(HWDATA);
				end
			endcase
		end
	end

	function automatic mcct_pkg::mcct_act_t mcct_act_sel(
		input logic [7:0] f,
		input int         i
	);
		mcct_act_sel = mcct_pkg::mcct_act_t'(f[2*i +: 2]);
	endfunction : mcct_act_sel

	function automatic mcct_pkg::mcct_out_t mcct_out_sel(
		input logic [7:0] f,
		input int         i
	);
		mcct_out_sel = mcct_pkg::mcct_out_t'(f[2*i +: 2]);
	endfunction : mcct_out_sel

	// ***********************************************************
	// Registers
	// ***********************************************************
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			st <= '0;
		else
			st <= next_st;
	end

	// ***********************************************************
	// Outputs
	// ***********************************************************
	assign HRDATA    = st.rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign MATCH_OUT = st.mout;
	assign TRIG_OUT  = st.trig;
	assign IRQ       = |(st.status & st.mask);

endmodule : mcct_timer

`default_nettype wire

// >>> verif/mcct_timer_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Port checks
// ********
module mcct_timer_checker (
	input wire logic        REF_CLK,
	input wire logic        RST,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic        HREADYOUT,
	input wire logic        HRESP,
	input wire logic        CAP_IN,
	input wire logic [3:0]  MATCH_OUT,
	input wire logic [4:0]  TRIG_OUT,
	input wire logic        IRQ
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	logic       wdp;
	logic [7:0] wda;
	logic       cap_q;
	logic [3:0] cap_age;
	wire        mwr = wdp && wda == mcct_pkg::ADDR_MOUT;
	wire        iwr = wdp && wda[7:4] == 4'h2;
	// Saturates so a long quiet pin never looks like a fresh edge
	always_ff @(posedge REF_CLK)
	begin
		wdp <= HSEL && HREADY && HTRANS[1] && HWRITE;
		wda <= HADDR[7:0];
		cap_q <= CAP_IN;
		if (RST)
			cap_age <= 4'hf;
		else if (CAP_IN != cap_q)
			cap_age <= 4'h0;
		else if (cap_age != 4'hf)
			cap_age <= cap_age + 4'h1;
	end
	sequence bus_idle;
		!RST && !(HSEL && HTRANS[1]) ##1 1'b1;
	endsequence
	ready_a: assert property (HREADYOUT)
		else $error("bus stalled");
	okay_a: assert property (!HRESP)
		else $error("error response");
	rdata_hold_a: assert property (bus_idle |-> $stable(HRDATA))
		else $error("read data moved");
	mout_cause_a: assert property (!$past(RST) && !$past(mwr) |->
		((MATCH_OUT ^ $past(MATCH_OUT)) & ~TRIG_OUT[3:0]) == 4'h0)
		else $error("output moved without hit");
	irq_rise_a: assert property ($rose(IRQ) |-> TRIG_OUT != 5'h0 ||
		$past(TRIG_OUT) != 5'h0 || $past(iwr) || $past(iwr, 2))
		else $error("irq without event");
	irq_fall_a: assert property (!$past(RST) && $fell(IRQ) |->
		$past(iwr) || $past(iwr, 2))
		else $error("irq dropped by itself");
	hit_once_a: assert property (TRIG_OUT[3:0] != 4'h0 |=>
		(TRIG_OUT[3:0] & $past(TRIG_OUT[3:0])) == 4'h0)
		else $error("match hit twice");
	cap_trig_a: assert property (TRIG_OUT[4] |->
		cap_age inside {[4'h1:4'h6]})
		else $error("capture without pin edge");
endmodule : mcct_timer_checker
`default_nettype wire

// >>> verif/mcct_pins.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Count and capture pin driver
// ********
module mcct_pins (
	input  wire logic clk,
	output logic      cnt_in,
	output logic      cap_in
);
	initial cnt_in = 1'b0;
	initial cap_in = 1'b0;
	// Gap of four or more keeps each level past the synchroniser
	task automatic pulse(input logic cap, input int n, input int gap);
		repeat (2 * n)
		begin
			repeat (gap) @(posedge clk);
			if (cap)
				cap_in <= ~cap_in;
			else
				cnt_in <= ~cnt_in;
		end
	endtask : pulse
endmodule : mcct_pins
`default_nettype wire

// >>> verif/mcct_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Bench top
// ********
module mcct_timer_tb;
	logic        REF_CLK = 1'b0;
	logic        RST = 1'b1;
	logic        HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0]  HTRANS = 2'h0;
	logic        HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0;
	logic        rd_ph = 1'b0;
	logic [31:0] HRDATA;
	logic        HREADYOUT, HRESP, COUNT_IN, CAP_IN, IRQ;
	logic [3:0]  MATCH_OUT;
	logic [4:0]  TRIG_OUT;
	logic [31:0] exp_q[$];
	int          n_errors = 0, n_tests = 0, n_cap = 0, k, m;
	// Narrow instance: counter registers use the low 16 bits
	mcct_timer #(.WIDTH(16)) uut (
		.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .COUNT_IN(COUNT_IN), .CAP_IN(CAP_IN),
		.MATCH_OUT(MATCH_OUT), .TRIG_OUT(TRIG_OUT), .IRQ(IRQ)
	);
	mcct_pins pins (.clk(REF_CLK), .cnt_in(COUNT_IN), .cap_in(CAP_IN));
	always #10 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK)
		if (rd_ph && HREADYOUT === 1'b1)
			check(HRDATA, exp_q.pop_front());
	always @(posedge REF_CLK)
		if (TRIG_OUT[4] === 1'b1)
			n_cap++;
	task automatic summarize;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask : check
	task automatic wt(input logic irq);
		int i;
		for (i = 0; i < 300; i++)
		begin
			@(posedge REF_CLK);
			if ((irq ? IRQ : HREADYOUT) === 1'b1)
				break;
		end
		if (i == 300)
		begin
			n_errors++;
			summarize();
		end
	endtask : wt
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] e);
		@(posedge REF_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		wt(1'b0);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		rd_ph <= !w;
		if (!w)
			exp_q.push_back(e);
		wt(1'b0);
		rd_ph <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, e);
	endtask : rd
	initial
	begin
		void'($urandom(32'h0a8f));
		repeat (16) @(posedge REF_CLK);
		RST <= 1'b0;
		// Reset values, two unmapped words among them
		for (k = 0; k < 17; k++)
			rd(8'(4 * k), 32'h0);
		// One match at a time: stop action, each output mode
		for (k = 0; k < 4; k++)
		begin
			m = 4 + $urandom % 20;
			wr(mcct_pkg::ADDR_COUNT, 32'h0);
			wr(mcct_pkg::ADDR_MATCH0 + 8'(4 * k), 32'(m));
			wr(mcct_pkg::ADDR_MCTRL, 32'h1 << 2 * k);
			wr(mcct_pkg::ADDR_OCTRL, 32'(k) << 2 * k);
			wr(mcct_pkg::ADDR_MOUT, 32'(k != 2) << k);
			wr(mcct_pkg::ADDR_MASK, 32'h1 << k);
			wr(mcct_pkg::ADDR_CTRL, 32'h1);
			wt(1'b1);
			check(32'(MATCH_OUT[k]), 32'(!k[0]));
			rd(mcct_pkg::ADDR_CTRL, 32'h0);
			rd(mcct_pkg::ADDR_COUNT, 32'(m));
			wr(mcct_pkg::ADDR_STATUS, 32'h1f);
			rd(mcct_pkg::ADDR_STATUS, 32'h0);
			check(32'(IRQ), 32'h0);
		end
		// Reset action on match 0 beside a continuing match 1
		// Count left at the last stop value would have to wrap first
		wr(mcct_pkg::ADDR_COUNT, 32'h0);
		wr(mcct_pkg::ADDR_MATCH0, 32'h3);
		wr(mcct_pkg::ADDR_MATCH0 + 8'h4, 32'h1);
		wr(mcct_pkg::ADDR_MCTRL, 32'h2);
		wr(mcct_pkg::ADDR_OCTRL, 32'h3);
		wr(mcct_pkg::ADDR_MASK, 32'h1);
		wr(mcct_pkg::ADDR_PRESC, 32'h1);
		wr(mcct_pkg::ADDR_CTRL, 32'h1);
		wt(1'b1);
		wr(mcct_pkg::ADDR_CTRL, 32'h0);
		check(32'(MATCH_OUT), 32'h1);
		rd(mcct_pkg::ADDR_STATUS, 32'h3);
		// Capture alone, then capture that also clears the count
		wr(mcct_pkg::ADDR_STATUS, 32'h1f);
		wr(mcct_pkg::ADDR_COUNT, 32'h1234);
		for (k = 1; k < 6; k += 4)
		begin
			wr(mcct_pkg::ADDR_CCTRL, 32'(k));
			pins.pulse(1'b1, 1, 4);
			repeat (8) @(posedge REF_CLK);
			rd(mcct_pkg::ADDR_CAPT, 32'h1234);
		end
		rd(mcct_pkg::ADDR_STATUS, 32'h10);
		rd(mcct_pkg::ADDR_COUNT, 32'h0);
		check(32'(n_cap), 32'h2);
		// Counter mode on rising, falling and both edges
		wr(mcct_pkg::ADDR_MCTRL, 32'h0);
		wr(mcct_pkg::ADDR_PRESC, 32'h0);
		for (k = 0; k < 3; k++)
		begin
			m = 1 + $urandom % 6;
			wr(mcct_pkg::ADDR_CCTRL, 32'(k) << 4);
			wr(mcct_pkg::ADDR_COUNT, 32'h0);
			wr(mcct_pkg::ADDR_CTRL, 32'h5);
			pins.pulse(1'b0, m, 4 + $urandom % 4);
			repeat (8) @(posedge REF_CLK);
			wr(mcct_pkg::ADDR_CTRL, 32'h0);
			rd(mcct_pkg::ADDR_COUNT, 32'(k == 2 ? 2 * m : m));
		end
		// Hold-reset bit forces the count to zero while enabled
		wr(mcct_pkg::ADDR_COUNT, 32'h5);
		wr(mcct_pkg::ADDR_CTRL, 32'h3);
		rd(mcct_pkg::ADDR_COUNT, 32'h0);
		wr(mcct_pkg::ADDR_CTRL, 32'h0);
		summarize();
	end
endmodule : mcct_timer_tb
bind mcct_timer mcct_timer_checker chk (
	.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .CAP_IN(CAP_IN),
	.MATCH_OUT(MATCH_OUT), .TRIG_OUT(TRIG_OUT), .IRQ(IRQ)
);
`default_nettype wire
